// ### src/sgc_ctrl.sv
/*
 Global mode and host-port link control registers of a five-port switch,
 with the forwarding, sniff and pre-tag decisions they steer.
 Assumes a single-cycle management register port on mclk, descriptor
 inputs from switch logic on mclk, and strap pins from outside the domain.
*/
// Summary of operation
// - VLAN enable bit 7 at 0x05 turns 802.1q forwarding on or off.
// - IGMP snoop bit sends every IGMP packet to the host port, except direct-mode requests.
// - Direct mode: host preamble gives destinations, internal lookup is skipped.
// - Pre-tag mode marks host-bound packets from the other ports with their source port number.
// - Tag mask mode uses low five vlan_identifier bits as destination port mask.
// - Tag mask works only while VLAN mode is off.
// - Sniff select set: mirror only when source and destination both match.
// - Sniff select clear: mirror when source or destination matches.
// - Bit 7 at 0x06 enables half-duplex back pressure on host port.
// - Bit 6 at 0x06 selects half duplex, clear means full duplex.
// - Duplex bit loads from its strap at reset, default full duplex.
// - Bit 5 at 0x06 enables full-duplex flow control on host port.
// - Flow control bit loads from its strap at reset, default off.
`timescale 1ns/1ps
module sgc_ctrl
	import sgc_pkg::*;
#(
	parameter int PORTS = SGC_PORTS
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [SGC_ADDR_W-1:0] reg_addr,
	input wire logic [SGC_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [SGC_DATA_W-1:0] reg_rdata_q,
	output logic reg_rvalid_q,
	input wire logic duplex_strap_pin,
	input wire logic flow_control_strap_pin,
	input wire logic pkt_valid,
	input wire logic [SGC_PORT_W-1:0] pkt_src_port,
	input wire logic pkt_is_igmp,
	input wire logic [SGC_VID_W-1:0] pkt_vid,
	input wire logic [PORTS-1:0] lookup_mask,
	input wire logic [PORTS-1:0] vlan_member_mask,
	input wire logic [PORTS-1:0] host_fwd_mask,
	input wire logic host_fwd_valid,
	input wire logic [PORTS-1:0] sniff_rx_ports,
	input wire logic [PORTS-1:0] sniff_tx_ports,
	output logic fwd_valid_q,
	output logic [PORTS-1:0] fwd_mask_q,
	output logic fwd_bypass_q,
	output logic mirror_q,
	output logic pretag_valid_q,
	output logic [SGC_PORT_W-1:0] pretag_port_q,
	output logic vlan_en_q,
	output logic tag_mask_active_q,
	output logic back_press_en_q,
	output logic half_duplex_q,
	output logic flow_ctrl_en_q
);
	// Sniff and host port masks are laid out for exactly five ports
	if (PORTS != SGC_PORTS)
	begin
		$error("sgc_ctrl supports only five ports");
	end

	logic [SGC_DATA_W-1:0] mode_q;
	logic duplex_s1_q;
	logic duplex_s2_q;
	logic flow_s1_q;
	logic flow_s2_q;
	logic [SGC_PORT_W-1:0] src_port_q;
	logic [PORTS-1:0] sniff_rx_q;
	logic [PORTS-1:0] sniff_tx_q;

	sgc_cfg_if cfg ();

	// Register decode
	wire logic hit_mode = (reg_addr == SGC_OFF_MODE_CTRL);
	wire logic hit_link = (reg_addr == SGC_OFF_LINK_CTRL);
	wire logic wr_mode = reg_wr && hit_mode;
	wire logic wr_link = reg_wr && hit_link;
	// Reserved bits masked out on write so they can never read back set
	wire logic [SGC_DATA_W-1:0] mode_d = reg_wdata & SGC_MODE_WR_MASK;

	wire logic [SGC_DATA_W-1:0] link_view = {back_press_en_q, half_duplex_q,
		flow_ctrl_en_q, 5'h00};
	wire logic [SGC_DATA_W-1:0] rdata_d = hit_mode ? (mode_q & SGC_MODE_WR_MASK)
		: hit_link ? link_view
		: '0;

	// Mode fields feeding the datapath
	wire logic vlan_en = mode_q[SGC_BIT_VLAN_EN];
	wire logic tag_mask_bit = mode_q[SGC_BIT_TAG_MASK];
	wire logic pretag_en = mode_q[SGC_BIT_PRETAG];
	wire logic sniff_and = mode_q[SGC_BIT_SNIFF_AND];

	assign cfg.vlan_en = vlan_en;
	assign cfg.igmp_snoop = mode_q[SGC_BIT_IGMP_SNOOP];
	assign cfg.direct_mode = mode_q[SGC_BIT_DIRECT];
	assign cfg.tag_mask_en = tag_mask_bit;

	sgc_fwd_sel #(
		.PORTS(PORTS)
	) u_fwd (
		.mclk(mclk),
		.srst(srst),
		.cfg(cfg),
		.pkt_valid(pkt_valid),
		.pkt_src_port(pkt_src_port),
		.pkt_is_igmp(pkt_is_igmp),
		.pkt_vid(pkt_vid),
		.lookup_mask(lookup_mask),
		.vlan_member_mask(vlan_member_mask),
		.host_fwd_mask(host_fwd_mask),
		.host_fwd_valid(host_fwd_valid),
		.fwd_valid_q(fwd_valid_q),
		.fwd_mask_q(fwd_mask_q),
		.fwd_bypass_q(fwd_bypass_q)
	);

	// Sniff match uses the same cycle as the destination result
	wire logic src_hit = sniff_rx_q[src_port_q];
	wire logic dst_hit = |(fwd_mask_q & sniff_tx_q);
	wire logic mirror_d = fwd_valid_q && (sniff_and ? (src_hit && dst_hit)
		: (src_hit || dst_hit));
	wire logic to_host = fwd_valid_q && fwd_mask_q[SGC_HOST_PORT];
	// A packet that came in on the host port gets no tag, even when its mask holds the host port
	wire logic pretag_d = pretag_en && to_host && (src_port_q != SGC_HOST_PORT);

	always_ff @(posedge mclk)
	begin
		if (srst)
			mode_q <= SGC_MODE_RESET;
		else if (wr_mode)
			mode_q <= mode_d;
	end

	// Strap synchronisers run freely so the level is settled while reset is held
	always_ff @(posedge mclk)
	begin
		duplex_s1_q <= duplex_strap_pin;
		duplex_s2_q <= duplex_s1_q;
		flow_s1_q <= flow_control_strap_pin;
		flow_s2_q <= flow_s1_q;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			back_press_en_q <= SGC_BACK_PRESS_RESET;
			half_duplex_q <= duplex_s2_q;
			flow_ctrl_en_q <= flow_s2_q;
		end
		else if (wr_link)
		begin
			back_press_en_q <= reg_wdata[SGC_BIT_BACK_PRESS];
			half_duplex_q <= reg_wdata[SGC_BIT_HALF_DUPLEX];
			flow_ctrl_en_q <= reg_wdata[SGC_BIT_FLOW_CTRL];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			reg_rdata_q <= '0;
			reg_rvalid_q <= 1'h0;
		end
		else
		begin
			reg_rdata_q <= reg_rd ? rdata_d : reg_rdata_q;
			reg_rvalid_q <= reg_rd;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			vlan_en_q <= 1'h0;
			tag_mask_active_q <= 1'h0;
		end
		else
		begin
			vlan_en_q <= vlan_en;
			tag_mask_active_q <= tag_mask_bit && !vlan_en;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			src_port_q <= '0;
			sniff_rx_q <= '0;
			sniff_tx_q <= '0;
		end
		else
		begin
			src_port_q <= pkt_src_port;
			sniff_rx_q <= sniff_rx_ports;
			sniff_tx_q <= sniff_tx_ports;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mirror_q <= 1'h0;
			pretag_valid_q <= 1'h0;
			pretag_port_q <= '0;
		end
		else
		begin
			mirror_q <= mirror_d;
			pretag_valid_q <= pretag_d;
			pretag_port_q <= pretag_d ? src_port_q : '0;
		end
	end
endmodule

// ### inc/sgc_pkg.sv
/*
 Constants for the switch global control bank: register offsets, field
 positions, reset values and port numbering.
 Assumes an 8-bit management register port and a five-port switch.
*/
package sgc_pkg;
	localparam int SGC_DATA_W = 8;
	localparam int SGC_ADDR_W = 8;
	localparam int SGC_PORTS = 5;
	localparam int SGC_PORT_W = 3;
	localparam int SGC_VID_W = 12;

	localparam logic [SGC_ADDR_W-1:0] SGC_OFF_MODE_CTRL = 8'h05;
	localparam logic [SGC_ADDR_W-1:0] SGC_OFF_LINK_CTRL = 8'h06;

	// Mode control register fields
	localparam int SGC_BIT_VLAN_EN = 7;
	localparam int SGC_BIT_IGMP_SNOOP = 6;
	localparam int SGC_BIT_DIRECT = 5;
	localparam int SGC_BIT_PRETAG = 4;
	localparam int SGC_BIT_TAG_MASK = 1;
	localparam int SGC_BIT_SNIFF_AND = 0;
	localparam logic [SGC_DATA_W-1:0] SGC_MODE_WR_MASK = 8'hF3;
	localparam logic [SGC_DATA_W-1:0] SGC_MODE_RESET = 8'h00;

	// Link control register fields
	localparam int SGC_BIT_BACK_PRESS = 7;
	localparam int SGC_BIT_HALF_DUPLEX = 6;
	localparam int SGC_BIT_FLOW_CTRL = 5;
	localparam logic SGC_BACK_PRESS_RESET = 1'h0;

	// Switch-side host port is the fifth port
	localparam logic [SGC_PORT_W-1:0] SGC_HOST_PORT = 3'h4;
	localparam logic [SGC_PORTS-1:0] SGC_HOST_MASK = 5'h10;
	localparam int SGC_TAG_MASK_W = 5;
endpackage

// ### inc/sgc_cfg_if.sv
/*
 Configuration carrier from the register bank to the forwarding selector.
 Assumes both ends share mclk.
*/
`timescale 1ns/1ps
interface sgc_cfg_if;
	logic vlan_en;
	logic igmp_snoop;
	logic direct_mode;
	logic tag_mask_en;

	modport ctl
	(
		output vlan_en,
		output igmp_snoop,
		output direct_mode,
		output tag_mask_en
	);
	modport fwd
	(
		input vlan_en,
		input igmp_snoop,
		input direct_mode,
		input tag_mask_en
	);
endinterface

// ### src/sgc_fwd_sel.sv
/*
 Destination selection for one packet descriptor under the global modes.
 Assumes descriptors arrive one per cycle from logic on mclk.
*/
`timescale 1ns/1ps
module sgc_fwd_sel
	import sgc_pkg::*;
#(
	parameter int PORTS = SGC_PORTS
)
(
	input wire logic mclk,
	input wire logic srst,
	sgc_cfg_if.fwd cfg,
	input wire logic pkt_valid,
	input wire logic [SGC_PORT_W-1:0] pkt_src_port,
	input wire logic pkt_is_igmp,
	input wire logic [SGC_VID_W-1:0] pkt_vid,
	input wire logic [PORTS-1:0] lookup_mask,
	input wire logic [PORTS-1:0] vlan_member_mask,
	input wire logic [PORTS-1:0] host_fwd_mask,
	input wire logic host_fwd_valid,
	output logic fwd_valid_q,
	output logic [PORTS-1:0] fwd_mask_q,
	output logic fwd_bypass_q
);
	// Vlan_identifier mask slice and host port mask are fixed at five ports
	if (PORTS != SGC_PORTS)
	begin
		$error("sgc_fwd_sel supports only five ports");
	end

	wire logic from_host = (pkt_src_port == SGC_HOST_PORT);
	wire logic use_direct = cfg.direct_mode && from_host && host_fwd_valid;
	wire logic use_tag = cfg.tag_mask_en && !cfg.vlan_en;
	wire logic [PORTS-1:0] vid_mask = pkt_vid[SGC_TAG_MASK_W-1:0];
	wire logic [PORTS-1:0] vlan_mask = cfg.vlan_en ? (lookup_mask & vlan_member_mask)
		: lookup_mask;
	wire logic [PORTS-1:0] base_mask = use_tag ? vid_mask : vlan_mask;
	wire logic [PORTS-1:0] snoop_mask = (cfg.igmp_snoop && pkt_is_igmp) ? SGC_HOST_MASK
		: '0;
	// Direct requests bypass lookup entirely; snoop cannot redirect them
	wire logic [PORTS-1:0] fwd_mask_d = use_direct ? host_fwd_mask : (base_mask | snoop_mask);

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			fwd_valid_q <= 1'h0;
			fwd_mask_q <= '0;
			fwd_bypass_q <= 1'h0;
		end
		else
		begin
			fwd_valid_q <= pkt_valid;
			fwd_mask_q <= pkt_valid ? fwd_mask_d : '0;
			fwd_bypass_q <= pkt_valid && use_direct;
		end
	end
endmodule

// ### dv/sgc_host_mac_model.sv
/*
 Host MAC model on the switch-side host port: direct-mode preamble info.
 Assumes the bench says when a preamble is present.
*/
`timescale 1ns/1ps
module sgc_host_mac_model
(
	input wire logic dir_en,
	input wire logic [4:0] dir_mask,
	output logic host_fwd_valid,
	output logic [4:0] host_fwd_mask
);
	// Without a preamble the lines show junk, so a stale mask cannot pass
	assign host_fwd_valid = dir_en;
	assign host_fwd_mask = dir_en ? dir_mask : ~dir_mask;
endmodule

// ### dv/sgc_ctrl_asserts.sv
/*
 Assertions on the global control bank ports.
 Assumes binding into sgc_ctrl, one clock mclk, reset srst.
*/
`timescale 1ns/1ps
module sgc_ctrl_asserts
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_rvalid_q,
	input wire logic pkt_valid,
	input wire logic [2:0] pkt_src_port,
	input wire logic fwd_valid_q,
	input wire logic mirror_q,
	input wire logic pretag_valid_q,
	input wire logic [2:0] pretag_port_q,
	input wire logic vlan_en_q,
	input wire logic tag_mask_active_q,
	input wire logic back_press_en_q,
	input wire logic half_duplex_q,
	input wire logic flow_ctrl_en_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_vlan_write: assert property (reg_wr && reg_addr == 8'h05 |-> ##2
		vlan_en_q == $past(reg_wdata[7], 2)) else $error("vlan enable");
	a_mask_vlan_off: assert property (reg_wr && reg_addr == 8'h05 |-> ##2
		tag_mask_active_q == ($past(reg_wdata[1], 2) && !$past(reg_wdata[7], 2)))
		else $error("tag mask with vlan");
	a_link_write: assert property (reg_wr && reg_addr == 8'h06 |=>
		{back_press_en_q, half_duplex_q, flow_ctrl_en_q} == $past(reg_wdata[7:5]))
		else $error("link bits");
	a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
		else $error("no read answer");
	a_rsvd_zero: assert property (reg_rd && reg_addr == 8'h05 |=>
		reg_rdata_q[3:2] == 2'h0) else $error("reserved bits");
	a_pretag_source: assert property (pretag_valid_q |-> $past(pkt_valid, 2) &&
		pretag_port_q == $past(pkt_src_port, 2)) else $error("pretag port");
	a_mirror_time: assert property (mirror_q |-> $past(pkt_valid, 2))
		else $error("mirror timing");
	a_fwd_time: assert property (pkt_valid |=> fwd_valid_q)
		else $error("fwd timing");
endmodule
bind sgc_ctrl sgc_ctrl_asserts sgc_ctrl_asserts_inst (.*);

// ### dv/testbench.sv
/*
 Random self-checking bench for the global control bank.
 Assumes the host MAC model drives the preamble info.
*/
`timescale 1ns/1ps
module testbench
	import sgc_pkg::*;
;
	logic mclk, srst, reg_wr, reg_rd, reg_rvalid_q, duplex_strap_pin, flow_control_strap_pin;
	logic pkt_valid, pkt_is_igmp, host_fwd_valid, dir_en, fwd_valid_q, fwd_bypass_q;
	logic mirror_q, pretag_valid_q, vlan_en_q, tag_mask_active_q;
	logic back_press_en_q, half_duplex_q, flow_ctrl_en_q;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
	logic [2:0] pkt_src_port, pretag_port_q;
	logic [11:0] pkt_vid;
	logic [4:0] lookup_mask, vlan_member_mask, host_fwd_mask, sniff_rx_ports;
	logic [4:0] sniff_tx_ports, fwd_mask_q, dir_mask;
	logic [31:0] seed;
	int n_mismatch, samples_checked;
	sgc_ctrl sgc_ctrl_inst (.*);
	sgc_host_mac_model sgc_host_mac_model_inst (.*);
	initial
	begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Destination mask per mode; snoop never alters a direct-mode request
	function logic [4:0] exp_mask(input logic [7:0] m, input logic [31:0] r,
		input logic [31:0] q, input logic b);
		logic [4:0] e;
		e = (m[1] && !m[7]) ? r[9:5] : m[7] ? q[4:0] & q[9:5] : q[4:0];
		e = e | ((m[6] && r[3]) ? 5'h10 : 5'h00);
		return b ? q[14:10] : e;
	endfunction
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rvalid_q, 8'h01);
		chk(reg_rdata_q, exp);
	endtask
	// Strap levels must settle through the syncs before reset lets go
	task do_reset(input logic d, input logic f);
		@(posedge mclk);
		duplex_strap_pin <= d;
		flow_control_strap_pin <= f;
		srst <= 1'h1;
		repeat (4) @(posedge mclk);
		srst <= 1'h0;
		@(posedge mclk);
		#1;
		chk(half_duplex_q, d);
		chk(flow_ctrl_en_q, f);
		chk(back_press_en_q, 8'h00);
		rd(8'h06, {1'h0, d, f, 5'h00});
		rd(8'h05, 8'h00);
	endtask
	task pkt(input logic [7:0] m);
		logic [31:0] r;
		logic [31:0] q;
		logic [2:0] s;
		logic [4:0] e;
		logic b;
		logic pv;
		r = rnd();
		q = rnd();
		s = (r[2:0] > 3'h4) ? 3'h4 : r[2:0];
		b = m[5] && s == 3'h4 && r[4];
		e = exp_mask(m, r, q, b);
		pv = m[4] && e[4] && s != 3'h4;
		@(posedge mclk);
		pkt_valid <= 1'h1;
		pkt_src_port <= s;
		pkt_is_igmp <= r[3];
		dir_en <= r[4];
		pkt_vid <= r[16:5];
		lookup_mask <= q[4:0];
		vlan_member_mask <= q[9:5];
		dir_mask <= q[14:10];
		sniff_rx_ports <= q[19:15];
		sniff_tx_ports <= q[24:20];
		@(posedge mclk);
		pkt_valid <= 1'h0;
		#1;
		chk(fwd_valid_q, 8'h01);
		chk(fwd_mask_q, e);
		chk(fwd_bypass_q, b);
		chk(vlan_en_q, m[7]);
		chk(tag_mask_active_q, m[1] && !m[7]);
		@(posedge mclk);
		#1;
		chk(mirror_q, m[0] ? q[15 + s] && |(e & q[24:20]) : q[15 + s] || |(e & q[24:20]));
		chk(pretag_valid_q, pv);
		chk(pretag_port_q, pv ? s : 3'h0);
	endtask
	task end_of_test();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		logic [7:0] m;
		seed = 32'he98f;
		n_mismatch = 0;
		samples_checked = 0;
		{reg_wr, reg_rd, pkt_valid, pkt_is_igmp, dir_en, reg_addr, reg_wdata, pkt_src_port} = '0;
		{pkt_vid, lookup_mask, vlan_member_mask, sniff_rx_ports, sniff_tx_ports, dir_mask} = '0;
		{duplex_strap_pin, flow_control_strap_pin} = '0;
		srst = 1'h1;
		do_reset(1'h0, 1'h0);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'hF3);
		wr(8'h33, 8'hFF);
		rd(8'h33, 8'h00);
		wr(8'h06, 8'hFF);
		rd(8'h06, 8'hE0);
		chk(back_press_en_q, 8'h01);
		for (int i = 0; i < 56; i++)
		begin
			// Walking single bits first, then random modes
			m = ((i < 8) ? 8'h01 << i : rnd() >> 8) & SGC_MODE_WR_MASK;
			wr(8'h05, m);
			pkt(m);
		end
		do_reset(1'h1, 1'h1);
		// Software may override the strap-loaded link bits
		wr(8'h06, 8'h80);
		rd(8'h06, 8'h80);
		chk(half_duplex_q, 8'h00);
		chk(flow_ctrl_en_q, 8'h00);
		end_of_test();
	end
endmodule
